/* File: inc/ccu_pkg.sv */
package ccu_pkg;

  // Register map
  localparam logic [7:0] CCU_FLAG_ADDR = 8'hf2;
  localparam logic [7:0] CCU_PLL_ADDR = 8'hf6;

  // Clock flag register bit positions
  localparam int FLAG_EXT_BIT = 7;
  localparam int FLAG_WDOG_BIT = 6;
  localparam int FLAG_HALTRST_BIT = 5;
  localparam int FLAG_XSTOP_BIT = 4;
  localparam int FLAG_SLOW_BIT = 3;
  localparam int FLAG_ALT_BIT = 2;
  localparam int FLAG_PLLSRC_BIT = 0;

  // PLL configuration field positions
  localparam int PLL_MULT_LSB = 4;
  localparam int PLL_MULT_MSB = 5;
  localparam int PLL_DIV_LSB = 0;
  localparam int PLL_DIV_MSB = 2;

  // Reset values
  localparam logic SLOW_RST = 1'b1;
  localparam logic [1:0] MULT_RST = 2'h0;
  localparam logic [2:0] DIV_OFF = 3'h7;

  // Multiplier codes and the factors they give
  localparam logic [1:0] MULT_C14 = 2'h2;
  localparam logic [1:0] MULT_C10 = 2'h0;
  localparam logic [1:0] MULT_C8 = 2'h3;
  localparam logic [1:0] MULT_C6 = 2'h1;
  localparam logic [3:0] MULT_X14 = 4'he;
  localparam logic [3:0] MULT_X10 = 4'ha;
  localparam logic [3:0] MULT_X8 = 4'h8;
  localparam logic [3:0] MULT_X6 = 4'h6;
  localparam logic [2:0] DIV_STEP = 3'h1;

  // Alternate clock is declared absent after this long without an edge
  localparam int CLK_PERIOD_NS = 10;
  localparam int ALT_LOSS_NS = 2000;
  localparam int ALT_LOSS_CYC = ALT_LOSS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SRC_HALF,
    SRC_PLL,
    SRC_SLOW16,
    SRC_ALT
  } ccu_src_t;

endpackage

/* File: logic/ccu_clock_ctl.sv */
// Behaviour
// - Stop-exit sets bit 7; software write of 0 clears
// - Reset value reflects watchdog, halt or power-on
// - Bit 6 read-only, set after watchdog reset
// - Bit 5 read-only, set after halt reset unless watchdog also caused the reset
// - Stop enable halts crystal while alt clock active
// - Stop enable reads 0 until alt runs; 0 cancels
// - Divide-by-16 select read/write, toggling raises interrupt
// - Select 0 gives slow clock, PLL off
// - Alt status set only when alt pin toggles
// - Hardware clears PLL source select on five events
// - Bit 0 picks half clock or PLL output
// - Active alternate clock overrides every other source
// - PLL config: multiplier 5:4, divider 2:0
// - Multiplier codes give 14, 10, 8, 6
// - Divider codes divide by code+1; 111 off
// - Halt disables oscillator, holds oscillator clock high
// - Watchdog enabled keeps oscillator running through halt
// - Clock interrupt masked while source select is 0
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

module ccu_clock_ctl
  import ccu_pkg::*;
#(
  parameter int ALT_LOSS = ALT_LOSS_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic WDOG_RST_CAUSE,
  input wire logic HALT_RST_CAUSE,
  input wire logic EXT_STOP_EXIT,
  input wire logic ALT_CLOCK_REQUEST,
  input wire logic LOW_POWER_WAIT_ENABLE,
  input wire logic LOW_POWER_WAIT_CLOCK_CHOICE,
  input wire logic INT_SOURCE_SELECT,
  input wire logic WAIT_FOR_IRQ,
  input wire logic WAIT_EXIT,
  input wire logic HALT_EXEC,
  input wire logic WDOG_ENABLED,
  input wire logic ALTERNATE_CLOCK_INPUT,
  output ccu_src_t SRC_SEL,
  output logic PLL_ON,
  output logic [3:0] PLL_MULT,
  output logic [2:0] PLL_DIV,
  output logic XTAL_RUN,
  output logic OSC_HOLD_HIGH,
  output logic CLK_IRQ_N
);

  localparam int CW = $clog2(ALT_LOSS + 1);
  localparam logic [CW-1:0] LOSS_LIM = CW'(ALT_LOSS);
  localparam logic [CW-1:0] CNT_STEP = CW'(1);

  typedef struct packed {
    logic cap_pend;
    logic ext_halt_flag;
    logic wdog_reset_flag;
    logic halt_reset_flag;
    logic xstop_req;
    logic slow_div_select;
    logic alt_clock_active;
    logic pll_source_select;
    logic [1:0] pll_mult_factor;
    logic [2:0] pll_out_divider;
    logic in_lpw;
    logic halted;
    logic alt_s1;
    logic alt_s2;
    logic alt_s3;
    logic [CW-1:0] alt_cnt;
    ccu_src_t src;
    logic pll_on;
    logic [3:0] mult_val;
    logic [2:0] div_val;
    logic xtal_run;
    logic osc_hold;
    logic irq_n;
    logic [7:0] rdata;
  } ccu_state_t;

  ccu_state_t st_r;
  ccu_state_t st_nxt;

  function automatic logic [3:0] mult_decode(input logic [1:0] code);
    case (code)
      MULT_C14: mult_decode = MULT_X14;
      MULT_C10: mult_decode = MULT_X10;
      MULT_C8: mult_decode = MULT_X8;
      MULT_C6: mult_decode = MULT_X6;
      default: mult_decode = MULT_X10;
    endcase
  endfunction

  function automatic logic [7:0] flag_image(input ccu_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[FLAG_EXT_BIT] = s.ext_halt_flag;
    v[FLAG_WDOG_BIT] = s.wdog_reset_flag;
    v[FLAG_HALTRST_BIT] = s.halt_reset_flag;
    v[FLAG_XSTOP_BIT] = s.xstop_req & s.alt_clock_active;
    v[FLAG_SLOW_BIT] = s.slow_div_select;
    v[FLAG_ALT_BIT] = s.alt_clock_active;
    v[FLAG_PLLSRC_BIT] = s.pll_source_select;
    flag_image = v;
  endfunction

  function automatic logic [7:0] pll_image(input ccu_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[PLL_MULT_MSB:PLL_MULT_LSB] = s.pll_mult_factor;
    v[PLL_DIV_MSB:PLL_DIV_LSB] = s.pll_out_divider;
    pll_image = v;
  endfunction

  logic wr_flag;
  logic wr_pll;
  assign wr_flag = WR && (ADDR == CCU_FLAG_ADDR);
  assign wr_pll = WR && (ADDR == CCU_PLL_ADDR);

  always_comb begin
    logic alt_present;
    logic alt_want;
    logic xstopped;
    logic lpw_entry;
    logic evt;
    alt_present = 1'b0;
    alt_want = 1'b0;
    xstopped = 1'b0;
    lpw_entry = 1'b0;
    evt = 1'b0;
    st_nxt = st_r;

    // Reset cause is sampled once, in the first cycle after release
    if (st_r.cap_pend) begin
      st_nxt.cap_pend = 1'b0;
      st_nxt.wdog_reset_flag = WDOG_RST_CAUSE;
      st_nxt.halt_reset_flag = HALT_RST_CAUSE && !WDOG_RST_CAUSE;
    end

    // Alternate clock pin: the second and third stages feed the edge check
    st_nxt.alt_s1 = ALTERNATE_CLOCK_INPUT;
    st_nxt.alt_s2 = st_r.alt_s1;
    st_nxt.alt_s3 = st_r.alt_s2;
    if (st_r.alt_s2 != st_r.alt_s3) begin
      st_nxt.alt_cnt = '0;
    end else if (st_r.alt_cnt != LOSS_LIM) begin
      st_nxt.alt_cnt = st_r.alt_cnt + CNT_STEP;
    end
    alt_present = (st_r.alt_cnt != LOSS_LIM);

    if (wr_flag) begin
      // Writing 1 to bit 7 leaves it alone; only 0 clears
      st_nxt.ext_halt_flag = st_r.ext_halt_flag & WDATA[FLAG_EXT_BIT];
      st_nxt.xstop_req = WDATA[FLAG_XSTOP_BIT];
      st_nxt.slow_div_select = WDATA[FLAG_SLOW_BIT];
      st_nxt.pll_source_select = WDATA[FLAG_PLLSRC_BIT];
    end
    // Set beats a clear in the same cycle
    if (EXT_STOP_EXIT) begin
      st_nxt.ext_halt_flag = 1'b1;
    end
    if (wr_pll) begin
      st_nxt.pll_mult_factor = WDATA[PLL_MULT_MSB:PLL_MULT_LSB];
      st_nxt.pll_out_divider = WDATA[PLL_DIV_MSB:PLL_DIV_LSB];
    end

    lpw_entry = WAIT_FOR_IRQ && LOW_POWER_WAIT_ENABLE;
    if (lpw_entry) begin
      st_nxt.in_lpw = 1'b1;
    end else if (WAIT_EXIT) begin
      st_nxt.in_lpw = 1'b0;
    end

    // A request without a live pin never takes effect
    alt_want = ALT_CLOCK_REQUEST ||
      (st_nxt.in_lpw && LOW_POWER_WAIT_CLOCK_CHOICE);
    st_nxt.alt_clock_active = alt_want && alt_present;

    // Watchdog must keep counting, so halt is ignored while it runs
    if (HALT_EXEC && !WDOG_ENABLED) begin
      st_nxt.halted = 1'b1;
    end

    xstopped = st_nxt.xstop_req && st_nxt.alt_clock_active;

    // Clears PLL source select on divider off, stop, halt, wait or slow select 0
    if (st_nxt.pll_out_divider == DIV_OFF || xstopped ||
        st_nxt.halted || lpw_entry || st_nxt.in_lpw ||
        !st_nxt.slow_div_select) begin
      st_nxt.pll_source_select = 1'b0;
    end

    if (st_nxt.alt_clock_active) begin
      st_nxt.src = SRC_ALT;
    end else if (st_nxt.in_lpw || !st_nxt.slow_div_select) begin
      st_nxt.src = SRC_SLOW16;
    end else if (st_nxt.pll_source_select) begin
      st_nxt.src = SRC_PLL;
    end else begin
      st_nxt.src = SRC_HALF;
    end

    st_nxt.pll_on = st_nxt.slow_div_select && !st_nxt.in_lpw &&
      (st_nxt.pll_out_divider != DIV_OFF) && !xstopped &&
      !st_nxt.halted;
    st_nxt.mult_val = mult_decode(st_nxt.pll_mult_factor);
    st_nxt.div_val = st_nxt.pll_out_divider + DIV_STEP;
    st_nxt.xtal_run = !xstopped && !st_nxt.halted;
    st_nxt.osc_hold = st_nxt.halted;

    evt = (st_nxt.slow_div_select != st_r.slow_div_select) ||
      (st_nxt.alt_clock_active != st_r.alt_clock_active) ||
      ((st_nxt.src == SRC_SLOW16) != (st_r.src == SRC_SLOW16));
    st_nxt.irq_n = !(evt && INT_SOURCE_SELECT);

    st_nxt.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        CCU_FLAG_ADDR: begin
          st_nxt.rdata = flag_image(st_r);
        end
        CCU_PLL_ADDR: begin
          st_nxt.rdata = pll_image(st_r);
        end
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= '0;
      st_r.cap_pend <= 1'b1;
      st_r.alt_cnt <= LOSS_LIM; // Pin counts as dead until an edge
      st_r.slow_div_select <= SLOW_RST;
      st_r.pll_mult_factor <= MULT_RST;
      st_r.pll_out_divider <= DIV_OFF;
      st_r.src <= SRC_HALF;
      st_r.mult_val <= MULT_X10;
      st_r.xtal_run <= 1'b1;
      st_r.irq_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA = st_r.rdata;
  assign SRC_SEL = st_r.src;
  assign PLL_ON = st_r.pll_on;
  assign PLL_MULT = st_r.mult_val;
  assign PLL_DIV = st_r.div_val;
  assign XTAL_RUN = st_r.xtal_run;
  assign OSC_HOLD_HIGH = st_r.osc_hold;
  assign CLK_IRQ_N = st_r.irq_n;

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_arm_stop;
    wr_flag && WDATA[FLAG_XSTOP_BIT];
  endsequence

  sequence s_cancel_stop;
    wr_flag && !WDATA[FLAG_XSTOP_BIT];
  endsequence

  sequence s_halt_cmd;
    HALT_EXEC && !WDOG_ENABLED;
  endsequence

  a_ext_flag_set: assert property (
    EXT_STOP_EXIT |=> st_r.ext_halt_flag ##1 (st_r.ext_halt_flag ||
      $past(wr_flag)))
    else $error("stop-exit flag not set");

  a_ext_flag_hold: assert property (
    st_r.ext_halt_flag && !wr_flag |=> st_r.ext_halt_flag)
    else $error("stop-exit flag lost without a write");

  a_reset_image: assert property (
    st_r.cap_pend && !WR |=> st_r.slow_div_select &&
      !st_r.pll_source_select && !st_r.ext_halt_flag &&
      (st_r.wdog_reset_flag == $past(WDOG_RST_CAUSE)))
    else $error("flag register reset image wrong");

  a_cause_readonly: assert property (
    !st_r.cap_pend && wr_flag |=> $stable(st_r.wdog_reset_flag) &&
      $stable(st_r.halt_reset_flag))
    else $error("reset cause bit changed by a write");

  a_xstop_stops: assert property (
    st_r.xstop_req && st_r.alt_clock_active |-> !XTAL_RUN)
    else $error("crystal running while stop is armed");

  a_xstop_cancel: assert property (
    s_arm_stop ##1 s_cancel_stop |=> !st_r.xstop_req ##1
      (!st_r.xstop_req || $past(wr_flag)))
    else $error("stop enable not cancelled by write of 0");

  a_xstop_reads0: assert property (
    RD && (ADDR == CCU_FLAG_ADDR) && !st_r.alt_clock_active
      |=> !RDATA[FLAG_XSTOP_BIT])
    else $error("stop enable reads 1 without alternate clock");

  a_toggle_irq: assert property (
    wr_flag && INT_SOURCE_SELECT &&
      (WDATA[FLAG_SLOW_BIT] != st_r.slow_div_select)
      |=> !CLK_IRQ_N ##1 (CLK_IRQ_N || $past(INT_SOURCE_SELECT)))
    else $error("no interrupt on divide select toggle");

  a_irq_masked: assert property (
    !INT_SOURCE_SELECT |=> CLK_IRQ_N)
    else $error("clock interrupt raised while masked");

  a_slow_source: assert property (
    !st_r.alt_clock_active && !st_r.slow_div_select
      |-> SRC_SEL == SRC_SLOW16 && !PLL_ON)
    else $error("slow select does not give slow clock");

  a_alt_absent: assert property (
    st_r.alt_cnt == LOSS_LIM |=> !st_r.alt_clock_active)
    else $error("alternate clock active without pin edges");

  a_div_off_clear: assert property (
    st_r.pll_out_divider == DIV_OFF |-> !st_r.pll_source_select &&
      !PLL_ON)
    else $error("PLL source kept with divider off");

  a_pll_select: assert property (
    st_r.pll_source_select && !st_r.alt_clock_active
      |-> SRC_SEL == SRC_PLL)
    else $error("PLL source select ignored");

  a_alt_priority: assert property (
    st_r.alt_clock_active |-> SRC_SEL == SRC_ALT)
    else $error("alternate clock not given priority");

  a_pll_readback: assert property (
    RD && (ADDR == CCU_PLL_ADDR) |=> RDATA ==
      {2'h0, $past(st_r.pll_mult_factor), 1'b0,
       $past(st_r.pll_out_divider)})
    else $error("PLL configuration readback wrong");

  a_mult_x14: assert property (
    st_r.pll_mult_factor == MULT_C14 |-> PLL_MULT == MULT_X14)
    else $error("multiplier code 10 does not give 14");

  a_div_value: assert property (
    st_r.pll_out_divider != DIV_OFF
      |-> PLL_DIV == st_r.pll_out_divider + DIV_STEP)
    else $error("divider value is not code plus one");

  a_halt_stops: assert property (
    s_halt_cmd |=> (!XTAL_RUN && OSC_HOLD_HIGH) [*3])
    else $error("halt did not stop the oscillator");

  a_wdog_halt: assert property (
    HALT_EXEC && WDOG_ENABLED && !st_r.halted |=> !OSC_HOLD_HIGH)
    else $error("halt stopped oscillator under watchdog");

endmodule

/* File: verif/ccu_clock_ctl_test.sv */
`timescale 1ns/1ps

module ccu_clock_ctl_test
  import ccu_pkg::*;
;
  localparam int LOSS = 8;
  // Stand-in for the PLL lock-in time, which the bench cannot see
  localparam int LOCK = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, wdog_cause = 1'b0, halt_cause = 1'b0;
  logic alt_req = 1'b0, lp_en = 1'b0, lp_alt = 1'b0, int_sel = 1'b0;
  logic wdog_en = 1'b0, alt_in = 1'b0, alt_tog = 1'b0, irq_seen = 1'b0;
  // Pulses: 0 stop exit, 1 wait entry, 2 wait exit, 3 halt
  logic [3:0] ev = 4'h0;
  logic [7:0] rdata;
  ccu_src_t src_sel;
  logic pll_on, xtal_run, osc_hold, irq_n;
  logic [3:0] pll_mult;
  logic [2:0] pll_div;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] seed = 32'hc5a222de;

  ccu_clock_ctl #(.ALT_LOSS(LOSS)) i_ccu_clock_ctl (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .WDOG_RST_CAUSE(wdog_cause),
    .HALT_RST_CAUSE(halt_cause), .EXT_STOP_EXIT(ev[0]),
    .ALT_CLOCK_REQUEST(alt_req), .LOW_POWER_WAIT_ENABLE(lp_en),
    .LOW_POWER_WAIT_CLOCK_CHOICE(lp_alt), .INT_SOURCE_SELECT(int_sel),
    .WAIT_FOR_IRQ(ev[1]), .WAIT_EXIT(ev[2]), .HALT_EXEC(ev[3]),
    .WDOG_ENABLED(wdog_en), .ALTERNATE_CLOCK_INPUT(alt_in),
    .SRC_SEL(src_sel), .PLL_ON(pll_on), .PLL_MULT(pll_mult),
    .PLL_DIV(pll_div), .XTAL_RUN(xtal_run), .OSC_HOLD_HIGH(osc_hold),
    .CLK_IRQ_N(irq_n)
  );

  always #5 clk = ~clk;

  // Fastest legal toggle; the design synchronises it anyway
  always @(posedge clk) begin
    if (alt_tog) alt_in <= ~alt_in;
    if (irq_n === 1'b0) irq_seen <= 1'b1;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [3:0] mult_of(input logic [1:0] c);
    case (c)
      2'h2: return 4'he;
      2'h0: return 4'ha;
      2'h3: return 4'h8;
      default: return 4'h6;
    endcase
  endfunction

  function automatic logic [2:0] div_of(input logic [2:0] c);
    return (c == 3'h7) ? 3'h0 : c + 3'h1;
  endfunction

  task automatic test_done();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Two writes to one address with no idle cycle between them
  task automatic wr_pair(input logic [7:0] a, input logic [7:0] d0,
    input logic [7:0] d1);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d0;
    @(posedge clk);
    wdata <= d1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 4'h0;
  endtask

  task automatic do_reset(input logic w, input logic h);
    @(posedge clk);
    rst <= 1'b1;
    wdog_cause <= w;
    halt_cause <= h;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(2);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    logic [31:0] r;
    logic [7:0] d;
    do_reset(1'b0, 1'b0);
    chk_reg(CCU_FLAG_ADDR, 8'h08);
    chk_reg(CCU_PLL_ADDR, 8'h07);
    chk({4'h0, pll_mult}, 8'h0a);
    chk({7'h0, pll_on}, 8'h00);
    do_reset(1'b1, 1'b1);
    chk_reg(CCU_FLAG_ADDR, 8'h48);
    do_reset(1'b0, 1'b1);
    chk_reg(CCU_FLAG_ADDR, 8'h28);
    wr_reg(CCU_FLAG_ADDR, 8'h44);
    chk_reg(CCU_FLAG_ADDR, 8'h20);
    do_reset(1'b0, 1'b0);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      d = {r[7:6], 2'(i), r[3], 3'(i / 3)};
      wr_reg(CCU_PLL_ADDR, d);
      tick(1);
      chk({4'h0, pll_mult}, {4'h0, mult_of(d[5:4])});
      chk({5'h0, pll_div}, {5'h0, div_of(d[2:0])});
      chk({7'h0, pll_on}, {7'h0, d[2:0] != 3'h7});
      chk_reg(CCU_PLL_ADDR, d & 8'h37);
    end
    wr_reg(CCU_PLL_ADDR, 8'h21);
    tick(LOCK);
    wr_reg(CCU_FLAG_ADDR, 8'h09);
    chk_reg(CCU_FLAG_ADDR, 8'h09);
    chk(8'(src_sel), 8'(SRC_PLL));
    wr_reg(CCU_PLL_ADDR, 8'h27);
    tick(2);
    chk_reg(CCU_FLAG_ADDR, 8'h08);
    chk(8'(src_sel), 8'(SRC_HALF));
    int_sel <= 1'b1;
    wr_reg(CCU_PLL_ADDR, 8'h21);
    tick(LOCK);
    wr_reg(CCU_FLAG_ADDR, 8'h09);
    tick(4);
    irq_seen = 1'b0;
    wr_reg(CCU_FLAG_ADDR, 8'h01);
    tick(4);
    chk({7'h0, irq_seen}, 8'h01);
    chk_reg(CCU_FLAG_ADDR, 8'h00);
    chk(8'(src_sel), 8'(SRC_SLOW16));
    chk({7'h0, pll_on}, 8'h00);
    int_sel <= 1'b0;
    tick(1);
    irq_seen = 1'b0;
    wr_reg(CCU_FLAG_ADDR, 8'h08);
    tick(LOCK);
    chk({7'h0, irq_seen}, 8'h00);
    pulse(0);
    tick(1);
    chk_reg(CCU_FLAG_ADDR, 8'h88);
    wr_reg(CCU_FLAG_ADDR, 8'h88);
    chk_reg(CCU_FLAG_ADDR, 8'h88);
    wr_reg(CCU_FLAG_ADDR, 8'h08);
    chk_reg(CCU_FLAG_ADDR, 8'h08);
    // A request with a dead pin must never take effect
    alt_req <= 1'b1;
    tick(20);
    chk_reg(CCU_FLAG_ADDR, 8'h08);
    chk(8'(src_sel), 8'(SRC_HALF));
    alt_req <= 1'b0;
    wr_reg(CCU_FLAG_ADDR, 8'h19);
    chk_reg(CCU_FLAG_ADDR, 8'h09);
    wr_reg(CCU_FLAG_ADDR, 8'h09);
    wr_pair(CCU_FLAG_ADDR, 8'h19, 8'h09);
    alt_tog <= 1'b1;
    alt_req <= 1'b1;
    tick(10);
    chk_reg(CCU_FLAG_ADDR, 8'h0d);
    chk(8'(src_sel), 8'(SRC_ALT));
    chk({7'h0, xtal_run}, 8'h01);
    wr_reg(CCU_FLAG_ADDR, 8'h1d);
    tick(2);
    chk({7'h0, xtal_run}, 8'h00);
    chk_reg(CCU_FLAG_ADDR, 8'h1c);
    alt_tog <= 1'b0;
    tick(LOSS + 10);
    chk_reg(CCU_FLAG_ADDR, 8'h08);
    chk({7'h0, xtal_run}, 8'h01);
    alt_req <= 1'b0;
    wr_reg(CCU_FLAG_ADDR, 8'h09);
    lp_en <= 1'b1;
    pulse(1);
    tick(2);
    chk(8'(src_sel), 8'(SRC_SLOW16));
    pulse(2);
    tick(2);
    chk_reg(CCU_FLAG_ADDR, 8'h08);
    chk(8'(src_sel), 8'(SRC_HALF));
    // Low-power wait that picks the alternate clock, stop armed
    alt_tog <= 1'b1;
    lp_alt <= 1'b1;
    wr_reg(CCU_FLAG_ADDR, 8'h18);
    pulse(1);
    tick(2);
    chk(8'(src_sel), 8'(SRC_ALT));
    chk({7'h0, xtal_run}, 8'h00);
    pulse(2);
    tick(2);
    chk({7'h0, xtal_run}, 8'h01);
    alt_tog <= 1'b0;
    lp_alt <= 1'b0;
    wr_reg(CCU_FLAG_ADDR, 8'h08);
    lp_en <= 1'b0;
    wdog_en <= 1'b1;
    pulse(3);
    tick(2);
    chk({6'h0, xtal_run, osc_hold}, 8'h02);
    wdog_en <= 1'b0;
    pulse(3);
    tick(2);
    chk({5'h0, xtal_run, osc_hold, pll_on}, 8'h02);
    do_reset(1'b0, 1'b0);
    chk({6'h0, xtal_run, osc_hold}, 8'h02);
    test_done();
  end
endmodule
